//--- logic/bldc_pkg.sv
// Shared constants, types and range decoding for the brushless servo core
`default_nettype none
package bldc_pkg;
  // Timing
  localparam int SYS_CLK_NS = 50;
  localparam int STOP_CLEAR_NS = 1000000;
  localparam int STOP_CLEAR_CYCLES = (STOP_CLEAR_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int REF_LOSS_CYCLES = 131071;
  localparam logic [7:0] PROT_DELAY_EDGES = 8'h40;
  // Range selection values
  localparam logic [10:0] RANGE_1024 = 11'h400;
  localparam logic [10:0] RANGE_512 = 11'h200;
  localparam logic [10:0] RANGE_256 = 11'h100;
  // Tacho Schmitt thresholds on the amplifier sample
  localparam logic [7:0] SCHMITT_HI = 8'hA0;
  localparam logic [7:0] SCHMITT_LO = 8'h60;
  // Speed loop
  localparam logic [7:0] DUTY_START = 8'hFF;
  localparam int GAIN_SHIFT = 2;
  localparam int LOCK_TOL_SHIFT = 4;

  typedef enum logic [1:0] {
    ST_STOP = 2'h0,
    ST_RUN = 2'h1,
    ST_LOCKOUT = 2'h3,
    ST_LOCK_STOP = 2'h2
  } servo_state_e;

  // Bit 0 is phase U, bit 1 V, bit 2 W
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } drive_s;

  typedef struct packed {
    logic [7:0] plus;
    logic [7:0] minus;
  } hall_pair_s;

  typedef struct packed {
    logic [10:0] count;
    logic [10:0] divisor;
  } range_s;

  // Open select pins read high, so the pins simply pass as levels
  function automatic range_s range_decode(input logic a, input logic b);
    range_s r;
    case ({a, b})
      2'b11: r = '{count: RANGE_1024, divisor: RANGE_1024};
      2'b10: r = '{count: RANGE_1024, divisor: RANGE_512};
      2'b01: r = '{count: RANGE_256, divisor: RANGE_256};
      default: r = '{count: RANGE_512, divisor: RANGE_512};
    endcase
    return r;
  endfunction : range_decode
endpackage : bldc_pkg
`default_nettype wire

//--- logic/hall_commutator.sv
// Hall comparators and six-step commutation decode
`timescale 1ns/1ps
`default_nettype none
module hall_commutator (
  input wire bldc_pkg::hall_pair_s i_hall_a,
  input wire bldc_pkg::hall_pair_s i_hall_b,
  input wire bldc_pkg::hall_pair_s i_hall_c,
  input wire logic i_reverse,
  output bldc_pkg::drive_s o_comm,
  output logic o_valid
);
  logic [2:0] code;
  logic [2:0] hi;
  logic [2:0] lo;

  // A sensor reads high only when plus strictly exceeds minus
  assign code = {i_hall_a.plus > i_hall_a.minus,
                 i_hall_b.plus > i_hall_b.minus,
                 i_hall_c.plus > i_hall_c.minus};

  // Six valid codes each pick one upper and one lower switch
  always_comb begin
    hi = 3'h0;
    lo = 3'h0;
    case (code)
      3'b001: begin hi = 3'h1; lo = 3'h2; end
      3'b011: begin hi = 3'h1; lo = 3'h4; end
      3'b010: begin hi = 3'h2; lo = 3'h4; end
      3'b110: begin hi = 3'h2; lo = 3'h1; end
      3'b100: begin hi = 3'h4; lo = 3'h1; end
      3'b101: begin hi = 3'h4; lo = 3'h2; end
      default: begin hi = 3'h0; lo = 3'h0; end
    endcase
  end

  // Reverse swaps the roles, which runs the field backwards
  assign o_comm = i_reverse ? bldc_pkg::drive_s'{high: lo, low: hi}
                            : bldc_pkg::drive_s'{high: hi, low: lo};
  assign o_valid = (code != 3'h0) && (code != 3'h7);
endmodule : hall_commutator
`default_nettype wire

//--- logic/vco_nco.sv
// Digital VCO: reference frequency times divisor, with fallback reference
`timescale 1ns/1ps
`default_nettype none
module vco_nco #(
  parameter int REF_LOSS = bldc_pkg::REF_LOSS_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clear,
  input wire logic i_ref_edge,
  input wire logic i_fallback_edge,
  input wire logic [10:0] i_divisor,
  output logic o_tick,
  output logic o_ref_lost
);
  typedef struct packed {
    logic [19:0] cnt;
    logic [19:0] per;
    logic [19:0] acc;
    logic [16:0] loss;
    logic lost;
    logic tick;
  } vco_state_s;

  vco_state_s st_q;
  vco_state_s st_d;
  logic ref_ev;
  logic [20:0] sum;

  // Fractional accumulator: one tick per per/divisor system cycles
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    sum = {1'b0, st_q.acc} + {10'h0, i_divisor};
    // A stopped reference hands timing to the protection node
    ref_ev = st_q.lost ? i_fallback_edge : i_ref_edge;
    if (i_ref_edge) begin
      st_d.loss = 17'h0;
      st_d.lost = 1'b0;
    end else if (st_q.loss == REF_LOSS[16:0]) begin
      st_d.lost = 1'b1;
    end else begin
      st_d.loss = st_q.loss + 17'h1;
    end
    if (ref_ev) begin
      st_d.per = st_q.cnt + 20'h1;
      st_d.cnt = 20'h0;
    end else if (st_q.cnt != 20'hFFFFF) begin
      st_d.cnt = st_q.cnt + 20'h1;
    end
    // No period measured yet means no ticks at all
    if (st_q.per != 20'h0) begin
      if (sum >= {1'b0, st_q.per}) begin
        st_d.acc = 20'(sum - {1'b0, st_q.per});
        st_d.tick = 1'b1;
      end else begin
        st_d.acc = sum[19:0];
      end
    end
    if (i_clear) begin
      st_d = '0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_tick = st_q.tick;
  assign o_ref_lost = st_q.lost;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  property p_no_period_no_tick;
    (st_q.per == 20'h0) |=> !o_tick;
  endproperty
  a_no_period_no_tick: assert property (p_no_period_no_tick)
    else $error("VCO ticked before a reference period was known");

  property p_fallback_restarts;
    (st_q.lost && i_fallback_edge && !i_clear && !i_ref_edge)
      |=> (st_q.cnt == 20'h0) && (st_q.per == $past(st_q.cnt) + 20'h1);
  endproperty
  a_fallback_restarts: assert property (p_fallback_restarts)
    else $error("Fallback edge did not time the reference period");
endmodule : vco_nco
`default_nettype wire

//--- logic/bldc_speed_servo_commutator.sv
// Brushless pre-driver core: commutation, PWM gating, speed servo, protection
`timescale 1ns/1ps
`default_nettype none
module bldc_speed_servo_commutator #(
  parameter int STOP_CLEAR_CYCLES = bldc_pkg::STOP_CLEAR_CYCLES,
  parameter int REF_LOSS_CYCLES = bldc_pkg::REF_LOSS_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_hall_a_plus,
  input wire logic [7:0] i_hall_a_minus,
  input wire logic [7:0] i_hall_b_plus,
  input wire logic [7:0] i_hall_b_minus,
  input wire logic [7:0] i_hall_c_plus,
  input wire logic [7:0] i_hall_c_minus,
  input wire logic [7:0] i_tacho_amp_output,
  input wire logic i_speed_reference_clock_in,
  input wire logic i_range_select_a,
  input wire logic i_range_select_b,
  input wire logic i_protect_timer_node,
  input wire logic i_protect_timer_osc,
  input wire logic i_start,
  input wire logic i_reverse,
  input wire logic [7:0] i_pwm_ramp,
  output bldc_pkg::drive_s o_drive,
  output logic o_speed_locked_flag,
  output logic o_tacho_pulse,
  output logic o_ref_lost,
  output logic signed [12:0] o_speed_error,
  output logic signed [12:0] o_phase_error
);
  typedef struct packed {
    bldc_pkg::servo_state_e fsm;
    logic tacho;
    logic ref_prev;
    logic osc_prev;
    logic [11:0] ticks;
    logic half;
    logic [10:0] ph;
    logic signed [12:0] spd_err;
    logic signed [12:0] ph_err;
    logic in_lock;
    logic spd_upd;
    logic [7:0] duty;
    logic [7:0] prot;
    logic [14:0] stop;
    bldc_pkg::drive_s drv;
  } servo_s;

  servo_s st_q;
  servo_s st_d;
  bldc_pkg::range_s rng;
  bldc_pkg::drive_s comm;
  logic comm_valid;
  logic vco_tick;
  logic tacho_edge;
  logic ref_edge;
  logic osc_edge;
  logic pwm_on;
  logic signed [12:0] serr;
  logic signed [12:0] perr;
  logic [12:0] abs_err;
  logic [12:0] tol;
  logic signed [13:0] adj;

  // Saturating duty step so a large error cannot wrap the duty
  function automatic logic [7:0] duty_step(input logic [7:0] d,
                                           input logic signed [13:0] a);
    logic signed [14:0] s;
    s = $signed({7'h0, d}) + 15'(a >>> bldc_pkg::GAIN_SHIFT);
    if (s < 15'sh0) return 8'h00;
    if (s > 15'sh00FF) return 8'hFF;
    return s[7:0];
  endfunction : duty_step

  hall_commutator u_hall (
    .i_hall_a(bldc_pkg::hall_pair_s'{plus: i_hall_a_plus, minus: i_hall_a_minus}),
    .i_hall_b(bldc_pkg::hall_pair_s'{plus: i_hall_b_plus, minus: i_hall_b_minus}),
    .i_hall_c(bldc_pkg::hall_pair_s'{plus: i_hall_c_plus, minus: i_hall_c_minus}),
    .i_reverse(i_reverse),
    .o_comm(comm),
    .o_valid(comm_valid)
  );

  // VCO runs at reference times divisor; cleared with the node reset
  vco_nco #(.REF_LOSS(REF_LOSS_CYCLES)) u_vco (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_clear(!i_protect_timer_node),
    .i_ref_edge(ref_edge),
    .i_fallback_edge(osc_edge),
    .i_divisor(rng.divisor),
    .o_tick(vco_tick),
    .o_ref_lost(o_ref_lost)
  );

  // Edge detection and range decode
  assign rng = bldc_pkg::range_decode(i_range_select_a, i_range_select_b);
  assign ref_edge = i_speed_reference_clock_in && !st_q.ref_prev;
  assign osc_edge = i_protect_timer_osc && !st_q.osc_prev;
  assign tacho_edge = (i_tacho_amp_output >= bldc_pkg::SCHMITT_HI) && !st_q.tacho;
  assign pwm_on = i_pwm_ramp < st_q.duty;

  // Error terms: ticks above count means the motor runs slow
  assign serr = $signed({1'b0, st_q.ticks}) - $signed({2'b0, rng.count});
  assign perr = (st_q.ph < (rng.count >> 1)) ? $signed({2'b0, st_q.ph})
              : $signed({2'b0, st_q.ph}) - $signed({2'b0, rng.count});
  assign abs_err = serr[12] ? 13'(-serr) : 13'(serr);
  assign tol = {2'b0, rng.count} >> bldc_pkg::LOCK_TOL_SHIFT;
  assign adj = (st_q.half ? st_q.spd_err : serr) + perr;

  always_comb begin
    st_d = st_q;
    st_d.spd_upd = 1'b0;
    st_d.ref_prev = i_speed_reference_clock_in;
    st_d.osc_prev = i_protect_timer_osc;
    // Hysteresis keeps noise near the crossing from making extra edges
    if (i_tacho_amp_output >= bldc_pkg::SCHMITT_HI) begin
      st_d.tacho = 1'b1;
    end else if (i_tacho_amp_output <= bldc_pkg::SCHMITT_LO) begin
      st_d.tacho = 1'b0;
    end
    // Count VCO ticks in the period and run the phase reference
    if (vco_tick) begin
      if (st_q.ticks != 12'hFFF) begin
        st_d.ticks = st_q.ticks + 12'h1;
      end
      // Wrap at or above the point, so a smaller new range cannot leave it stranded
      st_d.ph = (st_q.ph >= rng.count - 11'h1) ? 11'h0 : st_q.ph + 11'h1;
    end
    if (tacho_edge) begin
      st_d.ticks = 12'h0;
      st_d.half = !st_q.half;
      st_d.ph_err = perr;
      // Only every other period is measured and reported
      if (!st_q.half) begin
        st_d.spd_err = serr;
        st_d.spd_upd = 1'b1;
        st_d.in_lock = abs_err <= tol;
      end
      // Inside the band only phase steers; outside both terms do
      if ((!st_q.half && abs_err <= tol) || (st_q.half && st_q.in_lock)) begin
        st_d.duty = duty_step(st_q.duty, 14'(perr));
      end else begin
        st_d.duty = duty_step(st_q.duty, adj);
      end
    end
    // Start, run and stall protection
    case (st_q.fsm)
      bldc_pkg::ST_STOP: begin
        st_d.prot = 8'h0;
        st_d.duty = bldc_pkg::DUTY_START;
        if (i_start) begin
          st_d.fsm = bldc_pkg::ST_RUN;
        end
      end
      bldc_pkg::ST_RUN: begin
        if (!i_start) begin
          st_d.fsm = bldc_pkg::ST_STOP;
        end else if (st_q.in_lock) begin
          st_d.prot = 8'h0;
        end else if (osc_edge) begin
          // Delay counts node cycles, so it scales with its capacitor
          if (st_q.prot == bldc_pkg::PROT_DELAY_EDGES - 8'h1) begin
            st_d.fsm = bldc_pkg::ST_LOCKOUT;
          end else begin
            st_d.prot = st_q.prot + 8'h1;
          end
        end
      end
      bldc_pkg::ST_LOCKOUT: begin
        st_d.stop = 15'h0;
        if (!i_start) begin
          st_d.fsm = bldc_pkg::ST_LOCK_STOP;
        end
      end
      bldc_pkg::ST_LOCK_STOP: begin
        // A stop shorter than the clear time keeps the lockout
        if (i_start) begin
          st_d.fsm = bldc_pkg::ST_LOCKOUT;
        end else if (st_q.stop == 15'(STOP_CLEAR_CYCLES - 1)) begin
          st_d.fsm = bldc_pkg::ST_STOP;
        end else begin
          st_d.stop = st_q.stop + 15'h1;
        end
      end
      default: st_d.fsm = bldc_pkg::ST_STOP;
    endcase
    // Drive pattern; lockout keeps only the unchopped low side
    st_d.drv = '0;
    if (comm_valid && st_q.fsm == bldc_pkg::ST_RUN) begin
      st_d.drv.low = comm.low;
      st_d.drv.high = comm.high & {3{pwm_on}};
    end else if (comm_valid && st_q.fsm != bldc_pkg::ST_STOP) begin
      st_d.drv.low = comm.low;
    end
    // Low protection node is a power-on reset of the whole core
    if (!i_protect_timer_node) begin
      st_d = '0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs; the flag is high unless the last measured period was inside the band
  assign o_drive = st_q.drv;
  assign o_speed_locked_flag = !st_q.in_lock;
  assign o_tacho_pulse = st_q.tacho;
  assign o_speed_error = st_q.spd_err;
  assign o_phase_error = st_q.ph_err;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  property p_hall_equal_off;
    !comm_valid |=> (o_drive == '0);
  endproperty
  a_hall_equal_off: assert property (p_hall_equal_off)
    else $error("Drives active with all Hall inputs equal");

  property p_low_follows;
    (st_q.fsm != bldc_pkg::ST_STOP && i_protect_timer_node && comm_valid)
      |=> (o_drive.low == $past(comm.low));
  endproperty
  a_low_follows: assert property (p_low_follows)
    else $error("Low side did not follow commutation");

  property p_high_gated;
    !pwm_on |=> (o_drive.high == 3'h0);
  endproperty
  a_high_gated: assert property (p_high_gated)
    else $error("High side on outside PWM on time");

  property p_one_pair;
    $onehot0(o_drive.high) && $onehot0(o_drive.low) && ((o_drive.high & o_drive.low) == 3'h0);
  endproperty
  a_one_pair: assert property (p_one_pair)
    else $error("Illegal drive combination");

  property p_node_reset;
    !i_protect_timer_node |=> (o_drive == '0) && (st_q.fsm == bldc_pkg::ST_STOP);
  endproperty
  a_node_reset: assert property (p_node_reset)
    else $error("Core not held in reset by low protection node");

  property p_lock_band;
    (tacho_edge && !st_q.half && i_protect_timer_node)
      |=> (o_speed_locked_flag == ($past(abs_err) > $past(tol)));
  endproperty
  a_lock_band: assert property (p_lock_band)
    else $error("Lock flag disagrees with 6.25 percent band");

  property p_every_other;
    (tacho_edge && st_q.half) |=> !st_q.spd_upd ##1 (st_q.half == 1'b0);
  endproperty
  a_every_other: assert property (p_every_other)
    else $error("Speed error updated on a skipped period");

  property p_phase_update;
    (tacho_edge && i_protect_timer_node) |=> (o_phase_error == $past(perr));
  endproperty
  a_phase_update: assert property (p_phase_update)
    else $error("Phase error not updated at tacho edge");

  property p_lockout_high_off;
    (st_q.fsm == bldc_pkg::ST_LOCKOUT || st_q.fsm == bldc_pkg::ST_LOCK_STOP)
      |=> (o_drive.high == 3'h0);
  endproperty
  a_lockout_high_off: assert property (p_lockout_high_off)
    else $error("High side active during stall lockout");

  property p_stall_trip;
    (st_q.fsm == bldc_pkg::ST_RUN && !st_q.in_lock && osc_edge && i_start
      && i_protect_timer_node && st_q.prot == bldc_pkg::PROT_DELAY_EDGES - 8'h1)
      |=> (st_q.fsm == bldc_pkg::ST_LOCKOUT);
  endproperty
  a_stall_trip: assert property (p_stall_trip)
    else $error("Stall delay expired without lockout");

  property p_half_speed;
    (i_range_select_a && !i_range_select_b) |-> ({rng.divisor, 1'b0} == {1'b0, rng.count});
  endproperty
  a_half_speed: assert property (p_half_speed)
    else $error("Half speed setting does not halve the ratio");
endmodule : bldc_speed_servo_commutator
`default_nettype wire

//--- testbench/motor_model.sv
// Motor-side model: Hall sensor pairs and tacho amplifier samples
`timescale 1ns/1ps
`default_nettype none
module motor_model (
  input wire logic [2:0] i_hall_code,
  input wire logic [7:0] i_base,
  input wire logic i_tacho_hi,
  input wire logic i_mid,
  output bldc_pkg::hall_pair_s o_hall_a,
  output bldc_pkg::hall_pair_s o_hall_b,
  output bldc_pkg::hall_pair_s o_hall_c,
  output logic [7:0] o_tacho
);
  // A high sensor sits one count above its minus side; a low one ties it, the tightest case
  always_comb begin
    // Code bit 2 is sensor A, the same order the decoder packs its code in
    o_hall_a = '{plus: i_base + {7'h00, i_hall_code[2]}, minus: i_base};
    o_hall_b = '{plus: i_base + {7'h00, i_hall_code[1]}, minus: i_base};
    o_hall_c = '{plus: i_base + {7'h00, i_hall_code[0]}, minus: i_base};
  end

  // Tacho swing touches the thresholds; mid level sits inside the hysteresis band
  always_comb begin
    if (i_mid) begin
      o_tacho = 8'h80;
    end else if (i_tacho_hi) begin
      o_tacho = 8'hA0 | {3'h0, i_base[4:0]};
    end else begin
      o_tacho = 8'h60 - {3'h0, i_base[4:0]};
    end
  end
endmodule : motor_model
`default_nettype wire

//--- testbench/tb_bldc_speed_servo_commutator.sv
// Self-checking bench for the brushless servo core
`timescale 1ns/1ps
`default_nettype none
module tb_bldc_speed_servo_commutator;
  localparam int REF_PERIOD = 20480;
  localparam logic [5:0] COMM [8] = '{6'h00, 6'h0A, 6'h14, 6'h0C, 6'h21, 6'h22, 6'h11, 6'h00};
  localparam logic [1:0] ORDER [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] hall_code = 3'h1;
  logic [7:0] base = 8'h40;
  logic tacho_hi = 1'b0;
  logic mid = 1'b0;
  logic ref_on = 1'b0;
  logic [14:0] ref_cnt = 15'h0000;
  logic ref_lvl;
  logic sel_a = 1'b1;
  logic sel_b = 1'b1;
  logic node = 1'b1;
  logic osc = 1'b0;
  logic start = 1'b0;
  logic rev = 1'b0;
  logic [7:0] ramp = 8'h00;
  logic [31:0] seed = 32'h0000E3D7;
  int n_mismatch = 0;
  int total_checks = 0;
  bldc_pkg::hall_pair_s ha, hb, hc;
  logic [7:0] tacho;
  bldc_pkg::drive_s drive;
  logic flag, tpulse, rlost;
  logic signed [12:0] serr, perr;

  always #25 sys_clk = ~sys_clk;

  // Reference period of 20480 cycles keeps reference times 1024 at 1 MHz
  always @(negedge sys_clk) begin
    if (ref_on) begin
      ref_cnt <= (ref_cnt == 15'h4FFF) ? 15'h0000 : ref_cnt + 15'h0001;
    end
  end
  assign ref_lvl = ref_on && (ref_cnt < 15'h2800);

  motor_model i_motor_model (.i_hall_code(hall_code), .i_base(base), .i_tacho_hi(tacho_hi),
    .i_mid(mid), .o_hall_a(ha), .o_hall_b(hb), .o_hall_c(hc), .o_tacho(tacho));

  // Short stop-clear and loss spans keep the run brief; loss span still exceeds one ref period
  bldc_speed_servo_commutator #(.STOP_CLEAR_CYCLES(20), .REF_LOSS_CYCLES(21000))
    i_bldc_speed_servo_commutator (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
    .i_hall_a_plus(ha.plus), .i_hall_a_minus(ha.minus), .i_hall_b_plus(hb.plus),
    .i_hall_b_minus(hb.minus), .i_hall_c_plus(hc.plus), .i_hall_c_minus(hc.minus),
    .i_tacho_amp_output(tacho), .i_speed_reference_clock_in(ref_lvl),
    .i_range_select_a(sel_a), .i_range_select_b(sel_b), .i_protect_timer_node(node),
    .i_protect_timer_osc(osc), .i_start(start), .i_reverse(rev), .i_pwm_ramp(ramp),
    .o_drive(drive), .o_speed_locked_flag(flag), .o_tacho_pulse(tpulse),
    .o_ref_lost(rlost), .o_speed_error(serr), .o_phase_error(perr));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  // Ticks per tacho period minus the selected count
  function automatic int exp_err(input logic [1:0] s, input int tp);
    int cnt;
    int dv;
    cnt = s[1] ? 1024 : (s[0] ? 256 : 512);
    dv = s[1] ? (s[0] ? 1024 : 512) : (s[0] ? 256 : 512);
    return tp * dv / REF_PERIOD - cnt;
  endfunction : exp_err

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    total_checks++;
    if (got !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, e, got);
    end
  endtask : chk

  // Tick counts carry one tick of phase slack, so allow two either way
  task automatic near(input string what, input int e, input logic signed [12:0] got);
    total_checks++;
    if (^got === 1'bx || got < e - 2 || got > e + 2) begin
      n_mismatch++;
      $display("Error %s expected %0d seen %0d", what, e, got);
    end
  endtask : near

  // One drive step: st 0 stop, 1 run, 2 lockout
  task automatic step(input logic [2:0] h, input logic rv, input logic [7:0] rp,
                      input logic [1:0] st);
    logic [5:0] e;
    @(negedge sys_clk);
    seed = xs(seed);
    base = seed[7:0] & 8'h7F;
    hall_code = h;
    rev = rv;
    ramp = rp;
    @(negedge sys_clk);
    e = (st == 2'd0) ? 6'h00 : COMM[h];
    if (rv) e = {e[2:0], e[5:3]};
    if (rp == 8'hFF || st == 2'd2) e[5:3] = 3'h0;
    chk("drive", 32'(e), 32'(drive));
  endtask : step

  task automatic osc_pulses(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      osc = 1'b1;
      @(negedge sys_clk);
      osc = 1'b0;
    end
    @(negedge sys_clk);
  endtask : osc_pulses

  // Mid samples inside the hysteresis band must not move the squared pulse
  task automatic tacho_period(input int tp);
    seed = xs(seed);
    base = seed[7:0] & 8'h7F;
    tacho_hi = 1'b1;
    @(negedge sys_clk);
    chk("tacho_rise", 32'h1, 32'(tpulse));
    mid = 1'b1;
    repeat (tp / 2 - 1) @(negedge sys_clk);
    chk("tacho_hold_high", 32'h1, 32'(tpulse));
    tacho_hi = 1'b0;
    mid = 1'b0;
    @(negedge sys_clk);
    mid = 1'b1;
    repeat (tp / 2 - 1) @(negedge sys_clk);
    chk("tacho_hold_low", 32'h0, 32'(tpulse));
    mid = 1'b0;
  endtask : tacho_period

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // The tests need about 95000 cycles; the limit leaves a few thousand spare
  initial begin
    repeat (99000) @(posedge sys_clk);
    n_mismatch++;
    $display("Error watchdog expected done seen hang");
    wrap_up();
  end

  initial begin
    repeat (2) @(negedge sys_clk);
    chk("flag_in_reset", 32'h1, 32'(flag));
    chk("drive_in_reset", 32'h0, 32'(drive));
    rst_n = 1'b1;
    step(3'h1, 1'b0, 8'h00, 2'd0);
    start = 1'b1;
    // Every Hall code both ways, random ramp or ramp at full scale
    for (int i = 0; i < 32; i++) begin
      seed = xs(seed);
      step(i[2:0], i[3], i[4] ? 8'hFF : (seed[7:0] & 8'hFE), 2'd1);
    end
    osc_pulses(63);
    step(3'h1, 1'b0, 8'h00, 2'd1);
    osc_pulses(1);
    step(3'h1, 1'b0, 8'h00, 2'd2);
    start = 1'b0;
    repeat (10) @(negedge sys_clk);
    start = 1'b1;
    step(3'h3, 1'b0, 8'h00, 2'd2);
    start = 1'b0;
    repeat (25) @(negedge sys_clk);
    start = 1'b1;
    @(negedge sys_clk);
    step(3'h2, 1'b0, 8'h00, 2'd1);
    node = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("drive_node_low", 32'h0, 32'(drive));
    chk("flag_node_low", 32'h1, 32'(flag));
    node = 1'b1;
    @(negedge sys_clk);
    step(3'h4, 1'b1, 8'h10, 2'd1);
    chk("ref_lost_early", 32'h0, 32'(rlost));
    for (int k = 0; k < 22000 && rlost !== 1'b1; k++) @(negedge sys_clk);
    chk("ref_lost", 32'h1, 32'(rlost));
    // One node edge restarts the fallback period, so the next reference period is clean
    osc_pulses(1);
    ref_on = 1'b1;
    repeat (REF_PERIOD + 200) @(negedge sys_clk);
    chk("ref_restored", 32'h0, 32'(rlost));
    // Same short tacho period in every range: tick rate follows the divisor only
    for (int m = 0; m < 4; m++) begin
      sel_a = ORDER[m][1];
      sel_b = ORDER[m][0];
      repeat (3) tacho_period(1000);
      near("speed_error", exp_err(ORDER[m], 1000), serr);
      chk("flag_out_of_band", 32'h1, 32'(flag));
    end
    // Tacho at target for the last range selected
    repeat (2) tacho_period(REF_PERIOD);
    tacho_hi = 1'b1;
    repeat (3) @(negedge sys_clk);
    near("speed_error_locked", exp_err(2'h1, REF_PERIOD), serr);
    chk("flag_in_band", 32'h0, 32'(flag));
    // Phase error of range 256 lies within half a count either way
    chk("phase_error_span", 32'h1, 32'((perr >= 13'sh1F80) && (perr < 13'sh0080)));
    wrap_up();
  end
endmodule : tb_bldc_speed_servo_commutator
`default_nettype wire
